// >>> stl_pkg.sv
// Purpose: Shared constants for the torque limit select block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Limits are in percent of rated torque
package stl_pkg;

  localparam int unsigned STL_AW = 8;
  localparam logic [STL_AW-1:0] STL_CTRL_OFS = 8'h00;
  localparam logic [STL_AW-1:0] STL_FWD_INT_OFS = 8'h04;
  localparam logic [STL_AW-1:0] STL_REV_INT_OFS = 8'h08;
  localparam logic [STL_AW-1:0] STL_FWD_EXT_OFS = 8'h0C;
  localparam logic [STL_AW-1:0] STL_REV_EXT_OFS = 8'h10;
  localparam logic [STL_AW-1:0] STL_MAX_TRQ_OFS = 8'h14;
  localparam logic [STL_AW-1:0] STL_STATUS_OFS = 8'h18;
  localparam logic [STL_AW-1:0] STL_MTURN_OFS = 8'h1C;
  localparam logic [STL_AW-1:0] STL_IRQ_STAT_OFS = 8'h20;
  localparam logic [STL_AW-1:0] STL_IRQ_MASK_OFS = 8'h24;
  localparam logic [STL_AW-1:0] STL_WRAP_OFS = 8'h28;

  // Control register fields
  localparam int unsigned STL_CTRL_IN_FWD_BIT = 0;
  localparam int unsigned STL_CTRL_IN_REV_BIT = 1;
  localparam int unsigned STL_CTRL_OUT_FLAG_BIT = 2;
  localparam int unsigned STL_CTRL_ENC_SEL_BIT = 3;
  localparam int unsigned STL_CTRL_RESTART_BIT = 4;

  // Interrupt status fields
  localparam int unsigned STL_IRQ_LIM_BIT = 0;
  localparam int unsigned STL_IRQ_WRAP_FWD_BIT = 1;
  localparam int unsigned STL_IRQ_WRAP_REV_BIT = 2;
  localparam int unsigned STL_IRQ_W = 3;

  localparam int unsigned STL_LIM_W = 10;
  localparam logic [STL_LIM_W-1:0] STL_LIM_MAX = 10'h320;
  localparam logic [STL_LIM_W-1:0] STL_INT_RST = 10'h320;
  localparam logic [STL_LIM_W-1:0] STL_EXT_RST = 10'h064;
  localparam logic [STL_LIM_W-1:0] STL_MAX_TRQ_RST = 10'h12C;
  localparam logic [15:0] STL_WRAP_RST = 16'hFFFF;
  localparam logic [15:0] STL_MTURN_RST = 16'h0000;

  typedef enum logic [0:0] {
    STL_ENC_ABS = 1'b0,
    STL_ENC_INC = 1'b1
  } stl_enc_e;

endpackage : stl_pkg

// >>> stl_lim_sel.sv
// Purpose: Effective torque limit for one direction
// Assumes: All limits unsigned percent of rated torque
// Notes: Pure combinational, one instance per direction
`timescale 1ns/1ns
module stl_lim_sel
  import stl_pkg::*;
(
  input wire logic [STL_LIM_W-1:0] int_lim,
  input wire logic [STL_LIM_W-1:0] ext_lim,
  input wire logic ext_req,
  input wire logic [STL_LIM_W-1:0] max_trq,
  output logic [STL_LIM_W-1:0] eff_lim
);
  logic [STL_LIM_W-1:0] sel;

  always_comb begin
    if (ext_req && (ext_lim < int_lim)) begin
      sel = ext_lim;
    end else begin
      sel = int_lim;
    end
    eff_lim = (sel > max_trq) ? max_trq : sel;
  end
endmodule // stl_lim_sel

// >>> stl_torque_limit.sv
// Purpose: Torque limit select, limit flag and multiturn counter
// Assumes: Commands and step pulses come from logic on pclk
// Notes: Limit request pins are asynchronous and synchronised here
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ns
module stl_torque_limit
  import stl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [STL_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic fwd_ext_limit_req,
  input wire logic rev_ext_limit_req,
  input wire logic signed [15:0] trq_cmd,
  input wire logic trq_cmd_valid,
  output logic signed [15:0] trq_out,
  output logic torque_limited_flag,
  input wire logic mturn_fwd_step,
  input wire logic mturn_rev_step,
  output logic signed [15:0] mturn_count,
  output logic enc_incremental
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [STL_LIM_W-1:0] fwd_int_limit_pct;
    logic [STL_LIM_W-1:0] rev_int_limit_pct;
    logic [STL_LIM_W-1:0] fwd_ext_limit_pct;
    logic [STL_LIM_W-1:0] rev_ext_limit_pct;
    logic [STL_LIM_W-1:0] max_trq_pct;
    logic in_alloc_fwd;
    logic in_alloc_rev;
    logic out_alloc_flag;
    logic encoder_usage_sel;
    stl_enc_e enc_mode;
    logic [15:0] multiturn_wrap_limit;
    logic [15:0] mturn;
    logic [STL_IRQ_W-1:0] irq_stat;
    logic [STL_IRQ_W-1:0] irq_mask;
    logic irq;
    logic flag;
    logic limiting;
    logic [15:0] trq_out;
    logic fwd_s1;
    logic fwd_s2;
    logic rev_s1;
    logic rev_s2;
  } stl_state_s;

  stl_state_s st_ff;
  stl_state_s nxt_st;
  logic [STL_LIM_W-1:0] fwd_lim;
  logic [STL_LIM_W-1:0] rev_lim;
  logic fwd_req;
  logic rev_req;

  // Unallocated inputs read as open
  assign fwd_req = st_ff.fwd_s2 & st_ff.in_alloc_fwd;
  assign rev_req = st_ff.rev_s2 & st_ff.in_alloc_rev;

  stl_lim_sel u_fwd_sel (
    .int_lim(st_ff.fwd_int_limit_pct),
    .ext_lim(st_ff.fwd_ext_limit_pct),
    .ext_req(fwd_req),
    .max_trq(st_ff.max_trq_pct),
    .eff_lim(fwd_lim)
  );

  stl_lim_sel u_rev_sel (
    .int_lim(st_ff.rev_int_limit_pct),
    .ext_lim(st_ff.rev_ext_limit_pct),
    .ext_req(rev_req),
    .max_trq(st_ff.max_trq_pct),
    .eff_lim(rev_lim)
  );

  always_comb begin
    logic acc_start;
    logic acc_done;
    logic wr;
    logic rd;
    logic map_hit;
    logic val_ok;
    logic [31:0] rdat;
    logic signed [16:0] fwd_bound;
    logic signed [16:0] rev_bound;
    logic signed [16:0] cmd_x;
    logic [15:0] new_trq;
    logic clip;
    logic hold;
    logic [STL_IRQ_W-1:0] ev;
    logic wrap_std;
    acc_start = 1'b0;
    acc_done = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    map_hit = 1'b0;
    val_ok = 1'b0;
    rdat = 32'h0000_0000;
    fwd_bound = 17'sh00000;
    rev_bound = 17'sh00000;
    cmd_x = 17'sh00000;
    new_trq = 16'h0000;
    clip = 1'b0;
    hold = 1'b0;
    ev = '0;
    wrap_std = 1'b0;
    nxt_st = st_ff;

    // Pins are asynchronous to pclk
    // Only the second stage feeds logic
    nxt_st.fwd_s1 = fwd_ext_limit_req;
    nxt_st.fwd_s2 = st_ff.fwd_s1;
    nxt_st.rev_s1 = rev_ext_limit_req;
    nxt_st.rev_s2 = st_ff.rev_s1;

    // APB: one wait state, pready from a flop
    // Wait state gives the read mux a full cycle
    acc_start = psel & penable & ~st_ff.pready;
    acc_done = psel & penable & st_ff.pready;
    wr = acc_done & pwrite;
    rd = acc_done & ~pwrite;
    val_ok = (pwdata[31:STL_LIM_W] == '0) && (pwdata[STL_LIM_W-1:0] <= STL_LIM_MAX);

    case (paddr)
      STL_CTRL_OFS: begin
        map_hit = 1'b1;
        rdat[STL_CTRL_IN_FWD_BIT] = st_ff.in_alloc_fwd;
        rdat[STL_CTRL_IN_REV_BIT] = st_ff.in_alloc_rev;
        rdat[STL_CTRL_OUT_FLAG_BIT] = st_ff.out_alloc_flag;
        rdat[STL_CTRL_ENC_SEL_BIT] = st_ff.encoder_usage_sel;
      end
      STL_FWD_INT_OFS: begin
        map_hit = 1'b1;
        rdat[STL_LIM_W-1:0] = st_ff.fwd_int_limit_pct;
      end
      STL_REV_INT_OFS: begin
        map_hit = 1'b1;
        rdat[STL_LIM_W-1:0] = st_ff.rev_int_limit_pct;
      end
      STL_FWD_EXT_OFS: begin
        map_hit = 1'b1;
        rdat[STL_LIM_W-1:0] = st_ff.fwd_ext_limit_pct;
      end
      STL_REV_EXT_OFS: begin
        map_hit = 1'b1;
        rdat[STL_LIM_W-1:0] = st_ff.rev_ext_limit_pct;
      end
      STL_MAX_TRQ_OFS: begin
        map_hit = 1'b1;
        rdat[STL_LIM_W-1:0] = st_ff.max_trq_pct;
      end
      STL_STATUS_OFS: begin
        map_hit = 1'b1;
        rdat[0] = st_ff.flag;
        rdat[1] = fwd_req;
        rdat[2] = rev_req;
        rdat[3] = st_ff.enc_mode;
        rdat[25:16] = fwd_lim;
        rdat[9+4:4] = rev_lim;
      end
      STL_MTURN_OFS: begin
        map_hit = 1'b1;
        rdat[15:0] = st_ff.mturn;
      end
      STL_IRQ_STAT_OFS: begin
        map_hit = 1'b1;
        rdat[STL_IRQ_W-1:0] = st_ff.irq_stat;
      end
      STL_IRQ_MASK_OFS: begin
        map_hit = 1'b1;
        rdat[STL_IRQ_W-1:0] = st_ff.irq_mask;
      end
      STL_WRAP_OFS: begin
        map_hit = 1'b1;
        rdat[15:0] = st_ff.multiturn_wrap_limit;
      end
      default: begin
        map_hit = 1'b0;
      end
    endcase

    nxt_st.pready = acc_start;
    if (acc_start) begin
      nxt_st.prdata = pwrite ? 32'h0000_0000 : rdat;
      nxt_st.pslverr = ~map_hit;
      if (pwrite) begin
        case (paddr)
          STL_FWD_INT_OFS, STL_REV_INT_OFS, STL_FWD_EXT_OFS, STL_REV_EXT_OFS,
          STL_MAX_TRQ_OFS: begin
            nxt_st.pslverr = ~val_ok;
          end
          STL_STATUS_OFS, STL_MTURN_OFS, STL_IRQ_STAT_OFS: begin
            nxt_st.pslverr = 1'b1;
          end
          default: begin
            nxt_st.pslverr = ~map_hit;
          end
        endcase
      end
    end else if (acc_done) begin
      nxt_st.prdata = 32'h0000_0000;
      nxt_st.pslverr = 1'b0;
    end

    // Settings land at the completing edge and act at once, except encoder select, which waits for restart
    // Refused writes leave every setting untouched
    if (wr && !st_ff.pslverr) begin
      case (paddr)
        STL_CTRL_OFS: begin
          nxt_st.in_alloc_fwd = pwdata[STL_CTRL_IN_FWD_BIT];
          nxt_st.in_alloc_rev = pwdata[STL_CTRL_IN_REV_BIT];
          nxt_st.out_alloc_flag = pwdata[STL_CTRL_OUT_FLAG_BIT];
          nxt_st.encoder_usage_sel = pwdata[STL_CTRL_ENC_SEL_BIT];
          if (pwdata[STL_CTRL_RESTART_BIT]) begin
            nxt_st.enc_mode = stl_enc_e'(pwdata[STL_CTRL_ENC_SEL_BIT]);
            nxt_st.mturn = STL_MTURN_RST;
          end
        end
        STL_FWD_INT_OFS: nxt_st.fwd_int_limit_pct = pwdata[STL_LIM_W-1:0];
        STL_REV_INT_OFS: nxt_st.rev_int_limit_pct = pwdata[STL_LIM_W-1:0];
        STL_FWD_EXT_OFS: nxt_st.fwd_ext_limit_pct = pwdata[STL_LIM_W-1:0];
        STL_REV_EXT_OFS: nxt_st.rev_ext_limit_pct = pwdata[STL_LIM_W-1:0];
        STL_MAX_TRQ_OFS: nxt_st.max_trq_pct = pwdata[STL_LIM_W-1:0];
        STL_IRQ_MASK_OFS: nxt_st.irq_mask = pwdata[STL_IRQ_W-1:0];
        STL_WRAP_OFS: nxt_st.multiturn_wrap_limit = pwdata[15:0];
        default: begin
          nxt_st.irq_mask = st_ff.irq_mask;
        end
      endcase
    end

    // Clip the command against the limit for its sign
    if (trq_cmd_valid) begin
      // Reverse bound is the reverse limit negated
      fwd_bound = $signed({7'h00, fwd_lim});
      rev_bound = -$signed({7'h00, rev_lim});
      cmd_x = 17'(trq_cmd);
      if (cmd_x > fwd_bound) begin
        new_trq = fwd_bound[15:0];
        clip = 1'b1;
      end else if (cmd_x < rev_bound) begin
        new_trq = rev_bound[15:0];
        clip = 1'b1;
      end else begin
        new_trq = trq_cmd;
      end
      nxt_st.trq_out = new_trq;
      nxt_st.limiting = clip;
      // Flag leaves with the clipped sample, never a cycle late
      nxt_st.flag = clip & st_ff.out_alloc_flag;
    end else begin
      nxt_st.flag = st_ff.limiting & st_ff.out_alloc_flag;
    end
    ev[STL_IRQ_LIM_BIT] = nxt_st.flag & ~st_ff.flag;

    // Incremental use keeps no turn count
    // Opposite steps in one cycle cancel
    wrap_std = (st_ff.multiturn_wrap_limit == STL_WRAP_RST);
    hold = (st_ff.enc_mode == STL_ENC_INC) | (mturn_fwd_step == mturn_rev_step);
    if (!hold && mturn_fwd_step) begin
      if (wrap_std) begin
        nxt_st.mturn = st_ff.mturn + 16'h0001;
        ev[STL_IRQ_WRAP_FWD_BIT] = (st_ff.mturn == 16'h7FFF);
      end else if (st_ff.mturn >= st_ff.multiturn_wrap_limit) begin
        nxt_st.mturn = 16'h0000;
        ev[STL_IRQ_WRAP_FWD_BIT] = 1'b1;
      end else begin
        nxt_st.mturn = st_ff.mturn + 16'h0001;
      end
    end else if (!hold && mturn_rev_step) begin
      if (wrap_std) begin
        nxt_st.mturn = st_ff.mturn - 16'h0001;
        ev[STL_IRQ_WRAP_REV_BIT] = (st_ff.mturn == 16'h8000);
      end else if (st_ff.mturn == 16'h0000 || st_ff.mturn > st_ff.multiturn_wrap_limit) begin
        nxt_st.mturn = st_ff.multiturn_wrap_limit;
        ev[STL_IRQ_WRAP_REV_BIT] = 1'b1;
      end else begin
        nxt_st.mturn = st_ff.mturn - 16'h0001;
      end
    end

    // Clear only bits the read reported; a new event wins
    if (rd && paddr == STL_IRQ_STAT_OFS) begin
      nxt_st.irq_stat = (st_ff.irq_stat & ~st_ff.prdata[STL_IRQ_W-1:0]) | ev;
    end else begin
      nxt_st.irq_stat = st_ff.irq_stat | ev;
    end
    nxt_st.irq = |(nxt_st.irq_stat & st_ff.irq_mask);
  end

  // Clock enable low freezes every field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.fwd_int_limit_pct <= STL_INT_RST;
      st_ff.rev_int_limit_pct <= STL_INT_RST;
      st_ff.fwd_ext_limit_pct <= STL_EXT_RST;
      st_ff.rev_ext_limit_pct <= STL_EXT_RST;
      st_ff.max_trq_pct <= STL_MAX_TRQ_RST;
      st_ff.enc_mode <= STL_ENC_ABS;
      st_ff.multiturn_wrap_limit <= STL_WRAP_RST;
      st_ff.mturn <= STL_MTURN_RST;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign irq = st_ff.irq;
  assign trq_out = st_ff.trq_out;
  assign torque_limited_flag = st_ff.flag;
  assign mturn_count = st_ff.mturn;
  assign enc_incremental = st_ff.enc_mode;

endmodule // stl_torque_limit

// >>> stl_tl_properties.sv
// Purpose: Port checks for the torque limit select block
// Assumes: Standard wrap limit, clk_en held high
// Notes: Bound to every stl_torque_limit instance
`timescale 1ns/1ns
module stl_tl_properties
  import stl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [STL_AW-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic signed [15:0] trq_cmd,
  input wire logic trq_cmd_valid,
  input wire logic signed [15:0] trq_out,
  input wire logic torque_limited_flag,
  input wire logic mturn_fwd_step,
  input wire logic mturn_rev_step,
  input wire logic signed [15:0] mturn_count,
  input wire logic enc_incremental
);
  logic wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_out_range: assert property (trq_cmd_valid |=> trq_out <= 16'sh320 && trq_out >= -16'sh320)
    else $error("torque beyond range");
  a_fwd_bound: assert property (trq_cmd_valid && trq_cmd >= 0 |=>
    trq_out >= 0 && trq_out <= $past(trq_cmd)) else $error("forward torque grown");
  a_rev_bound: assert property (trq_cmd_valid && trq_cmd < 0 |=>
    trq_out <= 0 && trq_out >= $past(trq_cmd)) else $error("reverse torque grown");
  a_flag_cause: assert property ($rose(torque_limited_flag) |->
    $past(trq_cmd_valid) || $past(wr_done) || $past(wr_done, 2)) else $error("flag rose alone");
  a_count_fwd: assert property (mturn_fwd_step && !mturn_rev_step && !enc_incremental && !wr_done
    |=> mturn_count == 16'($past(mturn_count) + 16'sh1)) else $error("forward count wrong");
  a_count_rev: assert property (mturn_rev_step && !mturn_fwd_step && !enc_incremental && !wr_done
    |=> mturn_count == 16'($past(mturn_count) - 16'sh1)) else $error("reverse count wrong");
  a_count_hold: assert property ((mturn_fwd_step == mturn_rev_step || enc_incremental)
    && !wr_done |=> $stable(mturn_count)) else $error("count moved");
  a_enc_restart: assert property ($changed(enc_incremental) |->
    $past(wr_done) && $past(paddr) == STL_CTRL_OFS) else $error("encoder mode changed alone");
endmodule // stl_tl_properties
bind stl_torque_limit stl_tl_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .trq_cmd(trq_cmd), .trq_cmd_valid(trq_cmd_valid), .trq_out(trq_out),
  .torque_limited_flag(torque_limited_flag), .mturn_fwd_step(mturn_fwd_step),
  .mturn_rev_step(mturn_rev_step), .mturn_count(mturn_count), .enc_incremental(enc_incremental));

// >>> stl_host_model.sv
// Purpose: Host controller driving request pins and torque commands
// Assumes: One command per go pulse
// Notes: Pins settle four cycles before the command, past the synchroniser
`timescale 1ns/1ns
module stl_host_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic fwd_close,
  input wire logic rev_close,
  input wire logic signed [15:0] cmd,
  output logic fwd_ext_limit_req,
  output logic rev_ext_limit_req,
  output logic signed [15:0] trq_cmd,
  output logic trq_cmd_valid,
  output logic done
);
  logic [2:0] wait_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {fwd_ext_limit_req, rev_ext_limit_req, trq_cmd_valid, done, wait_ff} <= '0;
      trq_cmd <= '0;
    end else begin
      trq_cmd_valid <= 1'b0;
      done <= 1'b0;
      trq_cmd <= ~trq_cmd;
      if (go) begin
        fwd_ext_limit_req <= fwd_close;
        rev_ext_limit_req <= rev_close;
        wait_ff <= 3'h4;
      end else if (wait_ff != 3'h0) begin
        wait_ff <= wait_ff - 3'h1;
        if (wait_ff == 3'h1) begin
          trq_cmd <= cmd;
          trq_cmd_valid <= 1'b1;
          done <= 1'b1;
        end
      end
    end
  end
  // Limits come from the bench, several below the commanded torque
endmodule // stl_host_model

// >>> tb_top.sv
// Purpose: Self-checking bench for the torque limit select block
// Assumes: clk_en tied high
// Notes: Random commands from an xorshift seeded at 87
`timescale 1ns/1ns
module tb_top
  import stl_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, go, fc, rc, done;
  logic fwd_req, rev_req, tv, flag, enc, fs, rs, al;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, r;
  logic signed [15:0] tc, to, cnt, cmd;
  int num_errors, total_checks, cyc, fi, fe, ri, re, mx;
  stl_torque_limit DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .fwd_ext_limit_req(fwd_req),
    .rev_ext_limit_req(rev_req), .trq_cmd(tc), .trq_cmd_valid(tv), .trq_out(to),
    .torque_limited_flag(flag), .mturn_fwd_step(fs), .mturn_rev_step(rs),
    .mturn_count(cnt), .enc_incremental(enc));
  stl_host_model u_host (.pclk(pclk), .presetn(presetn), .go(go), .fwd_close(fc),
    .rev_close(rc), .cmd(cmd), .fwd_ext_limit_req(fwd_req), .rev_ext_limit_req(rev_req),
    .trq_cmd(tc), .trq_cmd_valid(tv), .done(done));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic signed [15:0] clip(input logic signed [15:0] c, input logic f,
      input logic rv, output logic lim);
    int fl, rl;
    fl = (f && fe < fi) ? fe : fi;
    rl = (rv && re < ri) ? re : ri;
    if (fl > mx) fl = mx;
    if (rl > mx) rl = mx;
    lim = (c > fl) || (c < -rl);
    return (c > fl) ? 16'(fl) : (c < -rl) ? 16'(-rl) : c;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run_cmd(input logic f, input logic rv, input logic signed [15:0] c);
    logic lim;
    logic signed [15:0] e;
    fc <= f;
    rc <= rv;
    cmd <= c;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    while (done !== 1'b1) begin
      @(posedge pclk);
    end
    @(negedge pclk);
    e = clip(c, f & al, rv & al, lim);
    chk("trq_out", 32'(e), 32'(to));
    chk("flag", {31'h0, lim & al}, {31'h0, flag});
    @(posedge pclk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  // Ceiling covers the 32K-step wrap walk with margin
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, go, fc, rc, fs, rs, al} = '0;
    paddr = '0;
    pwdata = '0;
    cmd = '0;
    seed = 87;
    {fi, fe, ri, re, mx} = {32'd800, 32'd100, 32'd800, 32'd100, 32'd300};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, STL_FWD_INT_OFS, 0);
    chk("fwd_int", 32'h320, rd);
    apb(0, STL_REV_EXT_OFS, 0);
    chk("rev_ext", 32'h64, rd);
    apb(0, 8'h3C, 0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1, STL_FWD_INT_OFS, 32'h321);
    chk("over_err", 32'h1, {31'h0, err});
    $display("test defaults done");
    {fi, fe, ri, re} = {32'd500, 32'd200, 32'd400, 32'd600};
    apb(1, STL_FWD_INT_OFS, 32'h1F4);
    apb(1, STL_FWD_EXT_OFS, 32'hC8);
    apb(1, STL_REV_INT_OFS, 32'h190);
    apb(1, STL_REV_EXT_OFS, 32'h258);
    apb(1, STL_IRQ_MASK_OFS, 32'h1);
    apb(1, STL_CTRL_OFS, 32'h7);
    al = 1;
    for (int i = 0; i < 48; i++) begin
      if (i == 16) begin
        apb(1, STL_CTRL_OFS, 32'h0);
        al = 0;
      end
      if (i == 32) begin
        apb(1, STL_MAX_TRQ_OFS, 32'h320);
        mx = 800;
        apb(1, STL_CTRL_OFS, 32'h7);
        al = 1;
      end
      r = xs();
      run_cmd(r[20], r[21], 16'(int'(r[15:0] % 900) * 2 - 899));
    end
    chk("irq", 32'h1, {31'h0, irq});
    apb(0, STL_IRQ_STAT_OFS, 0);
    chk("irq_stat", 32'h1, rd & 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    apb(1, STL_IRQ_MASK_OFS, 32'h0);
    run_cmd(0, 0, 16'sh1);
    run_cmd(0, 0, 16'sh1F5);
    chk("irq_mask", 32'h0, {31'h0, irq});
    apb(0, STL_IRQ_STAT_OFS, 0);
    chk("irq_stat2", 32'h1, rd);
    $display("test limits done");
    rs <= 1'b1;
    repeat (32769) @(posedge pclk);
    rs <= 1'b0;
    @(negedge pclk);
    chk("rev_wrap", 32'h7FFF, 32'(cnt));
    @(posedge pclk);
    fs <= 1'b1;
    @(posedge pclk);
    fs <= 1'b0;
    rs <= 1'b0;
    @(negedge pclk);
    chk("fwd_wrap", 32'hFFFF8000, 32'(cnt));
    @(posedge pclk);
    apb(0, STL_IRQ_STAT_OFS, 0);
    chk("wrap_stat", 32'h6, rd);
    $display("test multiturn done");
    apb(1, STL_CTRL_OFS, 32'hF);
    chk("enc_pending", 32'h0, {31'h0, enc});
    apb(1, STL_CTRL_OFS, 32'h1F);
    chk("enc_inc", 32'h1, {31'h0, enc});
    chk("count_clr", 32'h0, 32'(cnt));
    fs <= 1'b1;
    repeat (4) @(posedge pclk);
    fs <= 1'b0;
    @(negedge pclk);
    chk("inc_nocount", 32'h0, 32'(cnt));
    @(posedge pclk);
    apb(0, STL_CTRL_OFS, 0);
    chk("ctrl", 32'hF, rd);
    $display("test encoder done");
    complete_run();
  end
endmodule // tb_top
